// *** hdl/apd_defines.vh ***
// Constants for the address page and I/O port decoder
`ifndef APD_DEFINES_VH
`define APD_DEFINES_VH

// ----------------------------------------------------------------
// Memory pages: upper six address bits, 1024-byte pages
// ----------------------------------------------------------------
`define APD_PAGE_BITS      6
`define APD_PAGE_OFS_BITS  10
`define APD_PAGE_ROM0      6'h30
`define APD_PAGE_ROM1      6'h31
`define APD_PAGE_SYSRAM    6'h32
`define APD_PAGE_DISP      6'h33

// ----------------------------------------------------------------
// I/O ports: upper eight address bits
// ----------------------------------------------------------------
`define APD_PORT_SER_STAT  8'hF8
`define APD_PORT_SER_DATA  8'hF9
`define APD_PORT_TAPE_STAT 8'hFA
`define APD_PORT_TAPE_DATA 8'hFB
`define APD_PORT_KEY_STAT  8'hFC
`define APD_PORT_KEY_DATA  8'hFD
`define APD_PORT_PAR       8'hFE
`define APD_PORT_SENSE     8'hFF
`define APD_PORT_BITS      8

// ----------------------------------------------------------------
// Data input multiplexer select codes
// ----------------------------------------------------------------
`define APD_MUX_KEY        2'h0
`define APD_MUX_PAR        2'h1
`define APD_MUX_BIDIR      2'h2
`define APD_MUX_INT        2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define APD_PAR_OUT_RST    8'h00
`define APD_DATA_RST       8'h00
`define APD_DISP_ADDR_RST  10'h000

`endif

// *** hdl/apd_io_decode.v ***
// I/O port decoder: upper address byte to one-hot port strobes
`timescale 1ns/1ps
`include "apd_defines.vh"

module apd_io_decode (
    input  wire [7:0] port_i,
    input  wire       io_rd_i,
    input  wire       io_wr_i,
    output wire       ser_stat_rd_o,
    output wire       ser_data_rd_o,
    output wire       ser_data_wr_o,
    output wire       tape_stat_rd_o,
    output wire       tape_data_rd_o,
    output wire       tape_data_wr_o,
    output wire       key_stat_rd_o,
    output wire       key_data_rd_o,
    output wire       par_rd_o,
    output wire       par_wr_o,
    output wire       sense_rd_o
);

    // ----------------------------------------------------------------
    // Port compare
    // ----------------------------------------------------------------
    wire hit_ser_stat  = (port_i == `APD_PORT_SER_STAT);
    wire hit_ser_data  = (port_i == `APD_PORT_SER_DATA);
    wire hit_tape_stat = (port_i == `APD_PORT_TAPE_STAT);
    wire hit_tape_data = (port_i == `APD_PORT_TAPE_DATA);
    wire hit_key_stat  = (port_i == `APD_PORT_KEY_STAT);
    wire hit_key_data  = (port_i == `APD_PORT_KEY_DATA);
    wire hit_par       = (port_i == `APD_PORT_PAR);
    wire hit_sense     = (port_i == `APD_PORT_SENSE);

    // Each UART sees only its own strobes
    assign ser_stat_rd_o  = io_rd_i & hit_ser_stat;
    assign ser_data_rd_o  = io_rd_i & hit_ser_data;
    assign ser_data_wr_o  = io_wr_i & hit_ser_data;
    assign tape_stat_rd_o = io_rd_i & hit_tape_stat;
    assign tape_data_rd_o = io_rd_i & hit_tape_data;
    assign tape_data_wr_o = io_wr_i & hit_tape_data;
    assign key_stat_rd_o  = io_rd_i & hit_key_stat;
    assign key_data_rd_o  = io_rd_i & hit_key_data;
    assign par_rd_o       = io_rd_i & hit_par;
    assign par_wr_o       = io_wr_i & hit_par;
    assign sense_rd_o     = io_rd_i & hit_sense;

endmodule

// *** hdl/apd_decoder.v ***
// Address page and I/O port decoder with data input steering
//
// How it works
// - Internal memory is four contiguous 1024-byte pages; one select at most.
// - C000 to C3FF selects the first program ROM page.
// - C400 to C7FF selects the second program ROM page.
// - C800 to CBFF selects the system RAM page.
// - CC00 to CFFF selects the display RAM page.
// - Page selects come only from the top six address bits.
// - I/O strobes and the bidirectional bus enable come from top eight bits; internal bus enable and memory-read mux select from top six.
// - Display RAM is two-port; a CPU access beats a refresh fetch.
// - ROM and system RAM reads use internal bus; display reads do not.
// - Writes to both RAMs take data from the bidirectional bus.
// - Parallel output latches the bidirectional bus on its strobe and holds.
// - Parallel input lines feed one mux input directly, no latch.
// - Keyboard data has its own mux input; ready flag uses internal bus.
// - Sense strobe drives the eight switch bits onto the bidirectional bus.
// - Each UART is enabled only by its own strobes; status via internal bus.
// - Serial status strobe makes the serial UART drive status internally.
// - Reading received serial data switches the mux to the internal bus.
// - CPU input mux chooses keyboard, parallel, bidirectional or internal bus.
`timescale 1ns/1ps
`include "apd_defines.vh"

module apd_decoder #(
    parameter ADDR_W = 16,
    parameter DATA_W = 8
) (
    input  wire              mclk_i,
    input  wire              rst_b_i,
    input  wire              ce_i,
    input  wire [ADDR_W-1:0] addr_i,
    input  wire              mem_rd_i,
    input  wire              mem_wr_i,
    input  wire              io_rd_i,
    input  wire              io_wr_i,
    input  wire [DATA_W-1:0] bidir_bus_i,
    input  wire [DATA_W-1:0] int_bus_i,
    input  wire [DATA_W-1:0] key_lines_i,
    input  wire [DATA_W-1:0] par_in_lines_i,
    input  wire [DATA_W-1:0] sense_sw_i,
    input  wire              vid_fetch_i,
    input  wire [9:0]        vid_addr_i,
    output reg               rom0_sel_o,
    output reg               rom1_sel_o,
    output reg               sysram_sel_o,
    output reg               disp_sel_o,
    output reg               int_bus_en_o,
    output reg               sysram_we_o,
    output reg               disp_we_o,
    output reg  [DATA_W-1:0] ram_wdata_o,
    output reg               disp_cpu_grant_o,
    output reg               disp_vid_grant_o,
    output reg  [9:0]        disp_addr_o,
    output reg               ser_stat_rd_o,
    output reg               ser_data_rd_o,
    output reg               ser_data_wr_o,
    output reg               tape_stat_rd_o,
    output reg               tape_data_rd_o,
    output reg               tape_data_wr_o,
    output reg               key_stat_rd_o,
    output reg  [DATA_W-1:0] uart_wdata_o,
    output reg  [DATA_W-1:0] par_out_port_o,
    output reg  [DATA_W-1:0] bidir_bus_o,
    output reg               bidir_bus_oe_o,
    output reg  [1:0]        mux_sel_o,
    output reg  [DATA_W-1:0] cpu_data_o,
    output reg               ext_access_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function page_hit;
        input [ADDR_W-1:0] a;
        input [5:0]        code;
        begin
            page_hit = (a[ADDR_W-1:ADDR_W-`APD_PAGE_BITS] == code);
        end
    endfunction

    function [DATA_W-1:0] mux_pick;
        input [1:0]        sel;
        input [DATA_W-1:0] k;
        input [DATA_W-1:0] p;
        input [DATA_W-1:0] b;
        input [DATA_W-1:0] n;
        begin
            case (sel)
                `APD_MUX_KEY:   mux_pick = k;
                `APD_MUX_PAR:   mux_pick = p;
                `APD_MUX_BIDIR: mux_pick = b;
                `APD_MUX_INT:   mux_pick = n;
                default:        mux_pick = b;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // I/O port decode
    // ----------------------------------------------------------------
    wire io_ser_stat_rd;
    wire io_ser_data_rd;
    wire io_ser_data_wr;
    wire io_tape_stat_rd;
    wire io_tape_data_rd;
    wire io_tape_data_wr;
    wire io_key_stat_rd;
    wire io_key_data_rd;
    wire io_par_rd;
    wire io_par_wr;
    wire io_sense_rd;

    apd_io_decode u_io_decode (
        .port_i         (addr_i[ADDR_W-1:ADDR_W-`APD_PORT_BITS]),
        .io_rd_i        (io_rd_i),
        .io_wr_i        (io_wr_i),
        .ser_stat_rd_o  (io_ser_stat_rd),
        .ser_data_rd_o  (io_ser_data_rd),
        .ser_data_wr_o  (io_ser_data_wr),
        .tape_stat_rd_o (io_tape_stat_rd),
        .tape_data_rd_o (io_tape_data_rd),
        .tape_data_wr_o (io_tape_data_wr),
        .key_stat_rd_o  (io_key_stat_rd),
        .key_data_rd_o  (io_key_data_rd),
        .par_rd_o       (io_par_rd),
        .par_wr_o       (io_par_wr),
        .sense_rd_o     (io_sense_rd)
    );

    // ----------------------------------------------------------------
    // Next-state decode
    // ----------------------------------------------------------------
    reg              mem_cyc;
    reg              rom0_next;
    reg              rom1_next;
    reg              sysram_next;
    reg              disp_next;
    reg              int_rd_next;
    reg              io_any_next;
    reg              cpu_disp_next;
    reg              vid_disp_next;
    reg  [9:0]       disp_addr_next;
    reg  [1:0]       mux_next;
    reg  [DATA_W-1:0] par_out_next;
    reg              int_hit;
    reg              ext_next;
    reg              sysram_we_next;
    reg              disp_we_next;

    always @* begin
        mem_cyc     = mem_rd_i | mem_wr_i;
        // Pages are disjoint compares, so at most one select fires
        rom0_next   = mem_cyc & page_hit(addr_i, `APD_PAGE_ROM0);
        rom1_next   = mem_cyc & page_hit(addr_i, `APD_PAGE_ROM1);
        sysram_next = mem_cyc & page_hit(addr_i, `APD_PAGE_SYSRAM);
        disp_next   = mem_cyc & page_hit(addr_i, `APD_PAGE_DISP);

        // Display RAM is not on the internal bus
        int_hit     = rom0_next | rom1_next | sysram_next;
        int_rd_next = mem_rd_i & int_hit;

        // Both RAMs write from the bidirectional bus
        sysram_we_next = mem_wr_i & sysram_next;
        disp_we_next   = mem_wr_i & disp_next;

        io_any_next = io_ser_stat_rd | io_ser_data_rd | io_ser_data_wr |
                      io_tape_stat_rd | io_tape_data_rd | io_tape_data_wr |
                      io_key_stat_rd | io_key_data_rd | io_par_rd |
                      io_par_wr | io_sense_rd;

        // Nothing internal claimed the cycle: leave it to the backplane
        ext_next = (mem_cyc & ~(int_hit | disp_next)) |
                   ((io_rd_i | io_wr_i) & ~io_any_next);

        // CPU side of the display RAM wins over refresh
        cpu_disp_next = disp_next;
        vid_disp_next = vid_fetch_i & ~disp_next;
        if (disp_next) begin
            disp_addr_next = addr_i[`APD_PAGE_OFS_BITS-1:0];
        end else begin
            disp_addr_next = vid_addr_i;
        end

        // Default is the bidirectional bus: external memory and I/O,
        // display RAM and the sense switches all arrive there
        mux_next = `APD_MUX_BIDIR;
        if (int_rd_next) begin
            mux_next = `APD_MUX_INT;
        end else if (io_ser_stat_rd | io_tape_stat_rd | io_key_stat_rd) begin
            mux_next = `APD_MUX_INT;
        end else if (io_ser_data_rd | io_tape_data_rd) begin
            mux_next = `APD_MUX_INT;
        end else if (io_key_data_rd) begin
            mux_next = `APD_MUX_KEY;
        end else if (io_par_rd) begin
            mux_next = `APD_MUX_PAR;
        end

        // Latch holds until the next parallel write
        if (io_par_wr) begin
            par_out_next = bidir_bus_i;
        end else begin
            par_out_next = par_out_port_o;
        end
    end

    // ----------------------------------------------------------------
    // Memory page outputs
    // ----------------------------------------------------------------
    // Everything is registered, so the board sees each select one
    // clock after the address; the CPU wait logic must allow for it.
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rom0_sel_o       <= 1'b0;
            rom1_sel_o       <= 1'b0;
            sysram_sel_o     <= 1'b0;
            disp_sel_o       <= 1'b0;
            int_bus_en_o     <= 1'b0;
            sysram_we_o      <= 1'b0;
            disp_we_o        <= 1'b0;
            ram_wdata_o      <= `APD_DATA_RST;
            ext_access_o     <= 1'b0;
        end else if (ce_i) begin
            rom0_sel_o       <= rom0_next;
            rom1_sel_o       <= rom1_next;
            sysram_sel_o     <= sysram_next;
            disp_sel_o       <= disp_next;
            int_bus_en_o     <= int_rd_next;
            sysram_we_o      <= sysram_we_next;
            disp_we_o        <= disp_we_next;
            ram_wdata_o      <= bidir_bus_i;
            ext_access_o     <= ext_next;
        end
    end

    // ----------------------------------------------------------------
    // Display port outputs
    // ----------------------------------------------------------------
    // Refresh loses the port only in cycles the CPU really uses
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            disp_cpu_grant_o <= 1'b0;
            disp_vid_grant_o <= 1'b0;
            disp_addr_o      <= `APD_DISP_ADDR_RST;
        end else if (ce_i) begin
            disp_cpu_grant_o <= cpu_disp_next;
            disp_vid_grant_o <= vid_disp_next;
            disp_addr_o      <= disp_addr_next;
        end
    end

    // ----------------------------------------------------------------
    // I/O strobe outputs
    // ----------------------------------------------------------------
    // Load data follows the bus every cycle; only the strobe qualifies it
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ser_stat_rd_o    <= 1'b0;
            ser_data_rd_o    <= 1'b0;
            ser_data_wr_o    <= 1'b0;
            tape_stat_rd_o   <= 1'b0;
            tape_data_rd_o   <= 1'b0;
            tape_data_wr_o   <= 1'b0;
            key_stat_rd_o    <= 1'b0;
            uart_wdata_o     <= `APD_DATA_RST;
            par_out_port_o   <= `APD_PAR_OUT_RST;
        end else if (ce_i) begin
            ser_stat_rd_o    <= io_ser_stat_rd;
            ser_data_rd_o    <= io_ser_data_rd;
            // Transmit order is software's job; strobe only loads data
            ser_data_wr_o    <= io_ser_data_wr;
            tape_stat_rd_o   <= io_tape_stat_rd;
            tape_data_rd_o   <= io_tape_data_rd;
            tape_data_wr_o   <= io_tape_data_wr;
            key_stat_rd_o    <= io_key_stat_rd;
            uart_wdata_o     <= bidir_bus_i;
            par_out_port_o   <= par_out_next;
        end
    end

    // ----------------------------------------------------------------
    // CPU data outputs
    // ----------------------------------------------------------------
    // Switches own the bidirectional bus only during a sense read;
    // at all other times the enable stays low so nothing fights it.
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bidir_bus_o      <= `APD_DATA_RST;
            bidir_bus_oe_o   <= 1'b0;
            mux_sel_o        <= `APD_MUX_BIDIR;
            cpu_data_o       <= `APD_DATA_RST;
        end else if (ce_i) begin
            bidir_bus_o      <= sense_sw_i;
            bidir_bus_oe_o   <= io_sense_rd;
            mux_sel_o        <= mux_next;
            cpu_data_o       <= mux_pick(mux_next, key_lines_i, par_in_lines_i,
                                         bidir_bus_i, int_bus_i);
        end
    end

endmodule

// *** sim/apd_decoder_asserts.sv ***
// Port-level assertions for the address page and I/O port decoder
`timescale 1ns/1ps
module apd_decoder_chk (
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    input wire logic        ce_i,
    input wire logic [15:0] addr_i,
    input wire logic        mem_rd_i,
    input wire logic        mem_wr_i,
    input wire logic        io_rd_i,
    input wire logic        io_wr_i,
    input wire logic [7:0]  bidir_bus_i,
    input wire logic [7:0]  sense_sw_i,
    input wire logic        vid_fetch_i,
    input wire logic        rom0_sel_o,
    input wire logic        rom1_sel_o,
    input wire logic        sysram_sel_o,
    input wire logic        disp_sel_o,
    input wire logic        ext_access_o,
    input wire logic        disp_cpu_grant_o,
    input wire logic        disp_vid_grant_o,
    input wire logic [7:0]  par_out_port_o,
    input wire logic [7:0]  bidir_bus_o,
    input wire logic        bidir_bus_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire       mem_cyc = ce_i && (mem_rd_i || mem_wr_i) && !io_rd_i && !io_wr_i;
    wire       par_wr  = ce_i && io_wr_i && addr_i[15:8] == 8'hFE;
    wire [3:0] sels    = {rom0_sel_o, rom1_sel_o, sysram_sel_o, disp_sel_o};
    // --------------------------------------------------------------
    // Cycle shapes
    // --------------------------------------------------------------
    sequence s_page(pg);
        mem_cyc && addr_i[15:10] == pg;
    endsequence
    sequence s_port(p, strobe);
        ce_i && !mem_rd_i && !mem_wr_i && strobe && addr_i[15:8] == p;
    endsequence
    AST_ROM0_PAGE: assert property (s_page(6'h30) |=> sels == 4'h8)
        else $error("first rom page not selected");
    AST_ROM1_PAGE: assert property (s_page(6'h31) |=> sels == 4'h4)
        else $error("second rom page not selected");
    AST_SYSRAM_PAGE: assert property (s_page(6'h32) |=> sels == 4'h2)
        else $error("system ram page not selected");
    AST_DISP_PAGE: assert property (s_page(6'h33) |=> sels == 4'h1)
        else $error("display page not selected");
    AST_EXT_ONLY: assert property (mem_cyc && addr_i[15:12] != 4'hC |=>
        ext_access_o && sels == 4'h0)
        else $error("outside access raised a select");
    AST_PAR_LATCH: assert property (par_wr |=> par_out_port_o == $past(bidir_bus_i))
        else $error("parallel latch missed the bus");
    AST_PAR_HOLD: assert property (!par_wr |=> $stable(par_out_port_o))
        else $error("parallel latch changed without strobe");
    AST_SENSE_DRIVE: assert property (s_port(8'hFF, io_rd_i) |=>
        bidir_bus_oe_o && bidir_bus_o == $past(sense_sw_i))
        else $error("switch value not driven");
    AST_CPU_FIRST: assert property (s_page(6'h33) ##0 vid_fetch_i |=>
        disp_cpu_grant_o && !disp_vid_grant_o)
        else $error("refresh beat the processor");
endmodule
bind apd_decoder apd_decoder_chk u_chk (.mclk_i, .rst_b_i, .ce_i, .addr_i, .mem_rd_i,
    .mem_wr_i, .io_rd_i, .io_wr_i, .bidir_bus_i, .sense_sw_i, .vid_fetch_i, .rom0_sel_o,
    .rom1_sel_o, .sysram_sel_o, .disp_sel_o, .ext_access_o, .disp_cpu_grant_o,
    .disp_vid_grant_o, .par_out_port_o, .bidir_bus_o, .bidir_bus_oe_o);

// *** sim/apd_cpu_model.sv ***
// Processor bus-cycle model facing the decoder
`timescale 1ns/1ps
module apd_cpu_model (
    input  wire logic        mclk_i,
    output logic      [15:0] addr_o,
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic             io_rd_o,
    output logic             io_wr_o,
    output logic      [7:0]  dout_o
);
    initial begin
        addr_o = 16'h0000;
        {mem_rd_o, mem_wr_o, io_rd_o, io_wr_o} = 4'h0;
        dout_o = 8'h00;
    end
    // Kind: 0 memory read, 1 memory write, 2 port read, 3 port write
    task automatic cycle(input logic [1:0] kind, input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        {mem_rd_o, mem_wr_o, io_rd_o, io_wr_o} = 4'h8 >> kind;
        dout_o = d;
    endtask
    // Released lines show garbage, not the last value
    task automatic idle();
        @(negedge mclk_i);
        {mem_rd_o, mem_wr_o, io_rd_o, io_wr_o} = 4'h0;
        addr_o = ~addr_o;
        dout_o = ~dout_o;
    endtask
endmodule

// *** sim/apd_decoder_tb.sv ***
// Self-checking bench for the address page and I/O port decoder
`timescale 1ns/1ps
module apd_decoder_tb;
    logic        mclk_i, rst_b_i, ce_i, vid_fetch_i;
    logic [7:0]  int_bus_i, key_lines_i, par_in_lines_i, sense_sw_i;
    logic [9:0]  vid_addr_i;
    logic [31:0] rows [22];
    int          failures, samples_checked;
    wire  [15:0] addr;
    wire  [7:0]  cpu_dout, ram_wd, uart_wd, par_out, bidir_o, cpu_data;
    wire  [9:0]  disp_addr;
    wire  [6:0]  stb;
    wire  [3:0]  sel;
    wire  [1:0]  we, gnt, mux;
    wire         mem_rd, mem_wr, io_rd, io_wr, ibus_en, oe, ext;
    wire  [7:0]  bidir_bus = oe ? bidir_o : cpu_dout;
    wire  [13:0] obs = {sel, ext, stb, mux};
    apd_cpu_model u_apd_cpu_model (.mclk_i(mclk_i), .addr_o(addr), .mem_rd_o(mem_rd),
        .mem_wr_o(mem_wr), .io_rd_o(io_rd), .io_wr_o(io_wr), .dout_o(cpu_dout));
    apd_decoder u_apd_decoder (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .addr_i(addr), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .io_rd_i(io_rd),
        .io_wr_i(io_wr), .bidir_bus_i(bidir_bus), .int_bus_i(int_bus_i),
        .key_lines_i(key_lines_i), .par_in_lines_i(par_in_lines_i), .sense_sw_i(sense_sw_i),
        .vid_fetch_i(vid_fetch_i), .vid_addr_i(vid_addr_i), .rom0_sel_o(sel[3]),
        .rom1_sel_o(sel[2]), .sysram_sel_o(sel[1]), .disp_sel_o(sel[0]),
        .int_bus_en_o(ibus_en), .sysram_we_o(we[1]), .disp_we_o(we[0]), .ram_wdata_o(ram_wd),
        .disp_cpu_grant_o(gnt[1]), .disp_vid_grant_o(gnt[0]), .disp_addr_o(disp_addr),
        .ser_stat_rd_o(stb[6]), .ser_data_rd_o(stb[5]), .ser_data_wr_o(stb[4]),
        .tape_stat_rd_o(stb[3]), .tape_data_rd_o(stb[2]), .tape_data_wr_o(stb[1]),
        .key_stat_rd_o(stb[0]), .uart_wdata_o(uart_wd), .par_out_port_o(par_out),
        .bidir_bus_o(bidir_o), .bidir_bus_oe_o(oe), .mux_sel_o(mux), .cpu_data_o(cpu_data),
        .ext_access_o(ext));
    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One cycle then idle, so outputs of that cycle are settled on return
    task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        u_apd_cpu_model.cycle(k, a, d);
        u_apd_cpu_model.idle();
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // Whole run is near 80 cycles; 2000 means a hang
    initial begin
        #16000;
        failures++;
        final_report();
    end
    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        {rst_b_i, ce_i, vid_fetch_i, vid_addr_i} = {1'b0, 1'b1, 1'b0, 10'h000};
        {int_bus_i, key_lines_i, par_in_lines_i, sense_sw_i} = 32'h81_3C_96_5C;
        rows = '{{2'h0, 16'hC000, 14'h2003}, {2'h0, 16'hC3FF, 14'h2003},
            {2'h0, 16'hC400, 14'h1003}, {2'h1, 16'hC7FF, 14'h1002},
            {2'h0, 16'hC800, 14'h0803}, {2'h1, 16'hCBFF, 14'h0802},
            {2'h0, 16'hCC00, 14'h0402}, {2'h1, 16'hCFFF, 14'h0402},
            {2'h0, 16'hBFFF, 14'h0202}, {2'h0, 16'hD000, 14'h0202},
            {2'h2, 16'hF811, 14'h0103}, {2'h2, 16'hF922, 14'h0083},
            {2'h3, 16'hF933, 14'h0042}, {2'h2, 16'hFA44, 14'h0023},
            {2'h2, 16'hFB55, 14'h0013}, {2'h3, 16'hFB66, 14'h000A},
            {2'h2, 16'hFC77, 14'h0007}, {2'h2, 16'hFD88, 14'h0000},
            {2'h2, 16'hFE99, 14'h0001}, {2'h2, 16'hFFAA, 14'h0002},
            {2'h2, 16'h10BB, 14'h0202}, {2'h3, 16'hFECC, 14'h0002}};
        repeat (5) @(negedge mclk_i);
        chk({mux, par_out, obs}, {2'h2, 8'h00, 14'h0002});
        rst_b_i = 1'b1;
        foreach (rows[i]) begin
            op(rows[i][31:30], rows[i][29:14], rows[i][21:14]);
            chk(obs, rows[i][13:0]);
        end
        op(2'h2, 16'hFD00, 8'h00);
        chk(cpu_data, 8'h3C);
        op(2'h2, 16'hFE00, 8'h00);
        chk(cpu_data, 8'h96);
        op(2'h3, 16'hFE00, 8'hA5);
        op(2'h0, 16'hC000, 8'h11);
        chk(par_out, 8'hA5);
        // Transmit: status read first, data write after
        op(2'h2, 16'hF800, 8'h00);
        chk(cpu_data, 8'h81);
        op(2'h3, 16'hF900, 8'h41);
        chk({stb, uart_wd}, {7'h10, 8'h41});
        op(2'h2, 16'hFF00, 8'h00);
        chk({oe, bidir_o}, {1'h1, 8'h5C});
        op(2'h0, 16'hC123, 8'h00);
        chk(ibus_en, 1'h1);
        {vid_fetch_i, vid_addr_i} = {1'b1, 10'h3AB};
        op(2'h0, 16'hCC10, 8'h00);
        chk({gnt, disp_addr, ibus_en}, {2'h2, 10'h010, 1'h0});
        @(negedge mclk_i);
        chk({gnt, disp_addr}, {2'h1, 10'h3AB});
        op(2'h1, 16'hC805, 8'h5A);
        chk({we, ram_wd}, {2'h2, 8'h5A});
        op(2'h1, 16'hCC20, 8'hC3);
        chk({we, ram_wd}, {2'h1, 8'hC3});
        // Back to back with no idle between
        u_apd_cpu_model.cycle(2'h0, 16'hC400, 8'h00);
        u_apd_cpu_model.cycle(2'h2, 16'hFD00, 8'h00);
        chk(obs, 14'h1003);
        u_apd_cpu_model.idle();
        chk({obs, cpu_data}, {14'h0000, 8'h3C});
        // Clock enable low: a parallel write must not land
        ce_i = 1'b0;
        op(2'h3, 16'hFE00, 8'h5A);
        chk({obs, par_out, cpu_data}, {14'h0000, 8'hA5, 8'h3C});
        ce_i = 1'b1;
        // Mid-run reset clears the latch and the refresh grant
        rst_b_i = 1'b0;
        @(negedge mclk_i);
        chk({mux, par_out, obs, gnt}, {2'h2, 8'h00, 14'h0002, 2'h0});
        rst_b_i = 1'b1;
        op(2'h0, 16'hCC00, 8'h00);
        chk({obs, gnt}, {14'h0402, 2'h2});
        final_report();
    end
endmodule
